// ===== ambient_light_zone_params.svh
// Register map, reset values and field positions of the ambient light zone comparator.
// Behaviour
// - Status bits 3 to 0 show the live Level 5, Level 4, Level 3 and Level 2 comparator outputs.
// - A sensor code below the Level 2 threshold trips that comparator and selects the bright zone.
// - A sensor code above Level 2 threshold plus hysteresis selects the daylight zone.
// - A sensor code below the Level 3 threshold trips that comparator and selects the office zone.
// - The Level 2 threshold is an 8-bit code of 4.3 uA steps, code 250 being 1080 uA.
// - The Level 2 hysteresis is an 8-bit code of 4.3 uA steps, all ones being 1106 uA.
// - The Level 3 threshold is an 8-bit code of 2.16 uA steps, all ones being 550.8 uA.
// - Status bits 7 to 4 are reserved and read as zero.
// - Each level comparator and its automatic zone change run only while its enable bit is one.
`ifndef AMBIENT_LIGHT_ZONE_PARAMS_SVH
`define AMBIENT_LIGHT_ZONE_PARAMS_SVH

`define ALZ_CODE_W            8
`define ALZ_OFF_STATUS        8'h31
`define ALZ_OFF_BRIGHT_TRIP   8'h32
`define ALZ_OFF_BRIGHT_HYST   8'h33
`define ALZ_OFF_OFFICE_TRIP   8'h34
`define ALZ_RST_BRIGHT_TRIP   8'h00
`define ALZ_RST_BRIGHT_HYST   8'h00
`define ALZ_RST_OFFICE_TRIP   8'h00
`define ALZ_STAT_BRIGHT_BIT   0
`define ALZ_STAT_OFFICE_BIT   1
`define ALZ_STAT_INDOOR_BIT   2
`define ALZ_STAT_DARK_BIT     3
`define ALZ_STAT_RSVD         4'h0

`endif

// ===== ambient_light_zone_pkg.sv
// Types shared by the ambient light zone comparator.
package ambient_light_zone_pkg;
  typedef enum logic [1:0] {
    ZONE_DAYLIGHT,
    ZONE_BRIGHT,
    ZONE_OFFICE
  } zone_e;
endpackage

// ===== level_comparator.sv
// One hysteretic threshold comparator working in sensor code units.
`timescale 1ns/1ps
module level_comparator #(
  parameter int CODE_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              enable,
  input  wire logic              sampleValid,
  input  wire logic [CODE_W-1:0] sensorCode,
  input  wire logic [CODE_W-1:0] threshold,
  input  wire logic [CODE_W-1:0] hysteresis,
  output logic                   tripped
);
  logic [CODE_W:0] releaseLevel;
  logic            next_tripped;

  always_comb begin
    // One extra bit keeps a large threshold plus hysteresis from wrapping to a low value.
    releaseLevel = {1'b0, threshold} + {1'b0, hysteresis};
    next_tripped = tripped;
    if (!enable) begin
      next_tripped = 1'b0;
    end else if (sampleValid) begin
      if (sensorCode < threshold) begin
        next_tripped = 1'b1;
      end else if ({1'b0, sensorCode} > releaseLevel) begin
        next_tripped = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tripped <= 1'b0;
    end else begin
      tripped <= next_tripped;
    end
  end

  a_band_holds: assert property (@(posedge clk) disable iff (rst)
    enable && $past(enable) && sampleValid && sensorCode >= threshold
      && {1'b0, sensorCode} <= releaseLevel |=> $stable(tripped))
    else $error("comparator changed inside the hysteresis band");

  a_below_trips: assert property (@(posedge clk) disable iff (rst)
    enable && sampleValid && sensorCode < threshold |=> tripped)
    else $error("comparator did not trip below threshold");
endmodule // level_comparator

// ===== ambient_light_zone_comparator.sv
// Second-sensor zone comparator: threshold registers, status register and zone select.
`timescale 1ns/1ps
`include "ambient_light_zone_params.svh"
module ambient_light_zone_comparator #(
  parameter int CODE_W = `ALZ_CODE_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWriteData,
  output logic      [7:0]        regReadData,
  input  wire logic              sampleValid,
  input  wire logic [CODE_W-1:0] sensorCode,
  input  wire logic [3:0]        levelEnable,
  input  wire logic [CODE_W-1:0] officeZoneHysteresis,
  input  wire logic              indoorCompareIn,
  input  wire logic              darkCompareIn,
  output logic                   sensor_b_bright_compare_out,
  output logic                   sensor_b_office_compare_out,
  output logic                   sensor_b_indoor_compare_out,
  output logic                   sensor_b_dark_compare_out,
  output ambient_light_zone_pkg::zone_e zone
);
  // Threshold and hysteresis codes are stored raw; the uA scaling is analog-side only.
  logic [CODE_W-1:0] bright_zone_trip_threshold;
  logic [CODE_W-1:0] bright_zone_hysteresis;
  logic [CODE_W-1:0] office_zone_trip_threshold;
  logic [CODE_W-1:0] next_brightTrip;
  logic [CODE_W-1:0] next_brightHyst;
  logic [CODE_W-1:0] next_officeTrip;
  logic [7:0]        next_regReadData;
  logic [7:0]        statusWord;
  logic              brightTripped;
  logic              officeTripped;
  logic              next_indoor;
  logic              next_dark;
  ambient_light_zone_pkg::zone_e next_zone;

  level_comparator #(.CODE_W(CODE_W)) u_bright (
    .clk         (clk),
    .rst         (rst),
    .enable      (levelEnable[0]),
    .sampleValid (sampleValid),
    .sensorCode  (sensorCode),
    .threshold   (bright_zone_trip_threshold),
    .hysteresis  (bright_zone_hysteresis),
    .tripped     (brightTripped)
  );

  level_comparator #(.CODE_W(CODE_W)) u_office (
    .clk         (clk),
    .rst         (rst),
    .enable      (levelEnable[1]),
    .sampleValid (sampleValid),
    .sensorCode  (sensorCode),
    .threshold   (office_zone_trip_threshold),
    .hysteresis  (officeZoneHysteresis),
    .tripped     (officeTripped)
  );

  // Register writes. Codes above 250 or sums above 250 are accepted as written; keeping them
  // legal is left to host software, so no clamp hides a programming error.
  always_comb begin
    next_brightTrip = bright_zone_trip_threshold;
    next_brightHyst = bright_zone_hysteresis;
    next_officeTrip = office_zone_trip_threshold;
    if (regWrite) begin
      case (regAddr)
        `ALZ_OFF_BRIGHT_TRIP: next_brightTrip = regWriteData[CODE_W-1:0];
        `ALZ_OFF_BRIGHT_HYST: next_brightHyst = regWriteData[CODE_W-1:0];
        `ALZ_OFF_OFFICE_TRIP: next_officeTrip = regWriteData[CODE_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bright_zone_trip_threshold <= `ALZ_RST_BRIGHT_TRIP;
      bright_zone_hysteresis     <= `ALZ_RST_BRIGHT_HYST;
      office_zone_trip_threshold <= `ALZ_RST_OFFICE_TRIP;
    end else begin
      bright_zone_trip_threshold <= next_brightTrip;
      bright_zone_hysteresis     <= next_brightHyst;
      office_zone_trip_threshold <= next_officeTrip;
    end
  end

  // Status word and read data; unmapped or read-only-missing offsets read as zero.
  always_comb begin
    statusWord = {`ALZ_STAT_RSVD, sensor_b_dark_compare_out, sensor_b_indoor_compare_out,
                  sensor_b_office_compare_out, sensor_b_bright_compare_out};
    next_regReadData = regReadData;
    if (regRead) begin
      case (regAddr)
        `ALZ_OFF_STATUS:      next_regReadData = statusWord;
        `ALZ_OFF_BRIGHT_TRIP: next_regReadData = bright_zone_trip_threshold;
        `ALZ_OFF_BRIGHT_HYST: next_regReadData = bright_zone_hysteresis;
        `ALZ_OFF_OFFICE_TRIP: next_regReadData = office_zone_trip_threshold;
        default:              next_regReadData = 8'h00;
      endcase
    end
  end

  // Zone select: office outranks bright, and a disabled Level 2 leaves only the automatic change to office.
  always_comb begin
    next_indoor = indoorCompareIn & levelEnable[2];
    next_dark   = darkCompareIn & levelEnable[3];
    next_zone   = zone;
    if (levelEnable[1] && officeTripped) begin
      next_zone = ambient_light_zone_pkg::ZONE_OFFICE;
    end else if (levelEnable[0]) begin
      if (brightTripped) begin
        next_zone = ambient_light_zone_pkg::ZONE_BRIGHT;
      end else begin
        next_zone = ambient_light_zone_pkg::ZONE_DAYLIGHT;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regReadData                 <= 8'h00;
      sensor_b_bright_compare_out <= 1'b0;
      sensor_b_office_compare_out <= 1'b0;
      sensor_b_indoor_compare_out <= 1'b0;
      sensor_b_dark_compare_out   <= 1'b0;
      zone                        <= ambient_light_zone_pkg::ZONE_DAYLIGHT;
    end else begin
      regReadData                 <= next_regReadData;
      sensor_b_bright_compare_out <= brightTripped;
      sensor_b_office_compare_out <= officeTripped;
      sensor_b_indoor_compare_out <= next_indoor;
      sensor_b_dark_compare_out   <= next_dark;
      zone                        <= next_zone;
    end
  end

  a_status_reserved: assert property (@(posedge clk) disable iff (rst)
    regRead && regAddr == `ALZ_OFF_STATUS |=> regReadData[7:4] == 4'h0)
    else $error("reserved status bits not zero");

  a_status_live: assert property (@(posedge clk) disable iff (rst)
    regRead && regAddr == `ALZ_OFF_STATUS |=> regReadData[3:0] == {$past(sensor_b_dark_compare_out),
      $past(sensor_b_indoor_compare_out), $past(sensor_b_office_compare_out),
      $past(sensor_b_bright_compare_out)})
    else $error("status read does not match comparator outputs");

  a_office_zone: assert property (@(posedge clk) disable iff (rst)
    levelEnable[1] && officeTripped |=> zone == ambient_light_zone_pkg::ZONE_OFFICE)
    else $error("office zone not selected");

  a_bright_zone: assert property (@(posedge clk) disable iff (rst)
    levelEnable[0] && sampleValid && sensorCode < bright_zone_trip_threshold
      && !(levelEnable[1] && sampleValid && sensorCode < office_zone_trip_threshold)
      ##1 levelEnable[0] && !(levelEnable[1] && officeTripped)
      |=> zone == ambient_light_zone_pkg::ZONE_BRIGHT)
    else $error("bright zone not selected after trip");

  a_daylight_zone: assert property (@(posedge clk) disable iff (rst)
    levelEnable[0] && !brightTripped && !(levelEnable[1] && officeTripped)
      |=> zone == ambient_light_zone_pkg::ZONE_DAYLIGHT)
    else $error("daylight zone not selected");

  a_disabled_hold: assert property (@(posedge clk) disable iff (rst)
    !levelEnable[0] && !levelEnable[1] |=> $stable(zone))
    else $error("zone changed with comparators disabled");

  a_disabled_clear: assert property (@(posedge clk) disable iff (rst)
    !levelEnable[0] ##1 !levelEnable[0] |=> !sensor_b_bright_compare_out)
    else $error("disabled comparator output set");

  // A write lands at the edge that takes it, and the status offset stores nothing.
  a_trip_write: assert property (@(posedge clk) disable iff (rst)
    regWrite && regAddr == `ALZ_OFF_BRIGHT_TRIP
      |=> bright_zone_trip_threshold == $past(regWriteData[CODE_W-1:0]))
    else $error("bright threshold write did not land");

  a_hyst_write: assert property (@(posedge clk) disable iff (rst)
    regWrite && regAddr == `ALZ_OFF_BRIGHT_HYST
      |=> bright_zone_hysteresis == $past(regWriteData[CODE_W-1:0]))
    else $error("bright hysteresis write did not land");

  a_office_write: assert property (@(posedge clk) disable iff (rst)
    regWrite && regAddr == `ALZ_OFF_OFFICE_TRIP
      |=> office_zone_trip_threshold == $past(regWriteData[CODE_W-1:0]))
    else $error("office threshold write did not land");

  a_status_readonly: assert property (@(posedge clk) disable iff (rst)
    regWrite && regAddr == `ALZ_OFF_STATUS |=> $stable(bright_zone_trip_threshold)
      && $stable(bright_zone_hysteresis) && $stable(office_zone_trip_threshold))
    else $error("status write changed a threshold register");

  // The Level 4 and 5 results come from outside; only their gating by the enables is local.
  a_indoor_live: assert property (@(posedge clk) disable iff (rst)
    levelEnable[2] |=> sensor_b_indoor_compare_out == $past(indoorCompareIn))
    else $error("indoor status does not follow its comparator");

  a_dark_live: assert property (@(posedge clk) disable iff (rst)
    levelEnable[3] |=> sensor_b_dark_compare_out == $past(darkCompareIn))
    else $error("dark status does not follow its comparator");

  a_indoor_gated: assert property (@(posedge clk) disable iff (rst)
    !levelEnable[2] |=> !sensor_b_indoor_compare_out)
    else $error("disabled indoor status set");

  a_dark_gated: assert property (@(posedge clk) disable iff (rst)
    !levelEnable[3] |=> !sensor_b_dark_compare_out)
    else $error("disabled dark status set");

  a_office_clear: assert property (@(posedge clk) disable iff (rst)
    !levelEnable[1] ##1 !levelEnable[1] |=> !sensor_b_office_compare_out)
    else $error("disabled office status set");

  a_bright_release: assert property (@(posedge clk) disable iff (rst)
    levelEnable[0] && sampleValid
      && {1'b0, sensorCode} > {1'b0, bright_zone_trip_threshold}
        + {1'b0, bright_zone_hysteresis}
      |=> !brightTripped)
    else $error("bright comparator did not release above the band");

  a_office_release: assert property (@(posedge clk) disable iff (rst)
    levelEnable[1] && sampleValid
      && {1'b0, sensorCode} > {1'b0, office_zone_trip_threshold}
        + {1'b0, officeZoneHysteresis}
      |=> !officeTripped)
    else $error("office comparator did not release above the band");
endmodule // ambient_light_zone_comparator

// ===== ambient_light_zone_comparator_bench.sv
// Self-checking testbench of the ambient light zone comparator.
`timescale 1ns/1ps
module ambient_light_zone_comparator_bench;
  logic                          clk;
  logic                          rst;
  logic                          regWrite;
  logic                          regRead;
  logic                          sampleValid;
  logic                          indoorCompareIn;
  logic                          darkCompareIn;
  logic [7:0]                    regAddr;
  logic [7:0]                    regWriteData;
  logic [7:0]                    regReadData;
  logic [7:0]                    sensorCode;
  logic [7:0]                    officeZoneHysteresis;
  logic [3:0]                    levelEnable;
  logic                          brightOut;
  logic                          officeOut;
  logic                          indoorOut;
  logic                          darkOut;
  ambient_light_zone_pkg::zone_e zone;
  int                            bad_count;
  int                            comparisons;
  int                            cycles;

  ambient_light_zone_comparator u_ambient_light_zone_comparator (
    .clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWriteData(regWriteData), .regReadData(regReadData), .sampleValid(sampleValid),
    .sensorCode(sensorCode), .levelEnable(levelEnable),
    .officeZoneHysteresis(officeZoneHysteresis), .indoorCompareIn(indoorCompareIn),
    .darkCompareIn(darkCompareIn), .sensor_b_bright_compare_out(brightOut),
    .sensor_b_office_compare_out(officeOut), .sensor_b_indoor_compare_out(indoorOut),
    .sensor_b_dark_compare_out(darkOut), .zone(zone));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // A hang is cut short well beyond the 131 cycles the scenarios need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  task automatic chkZone(input ambient_light_zone_pkg::zone_e e);
    comparisons++;
    if (zone !== e) begin
      $display("mismatch zone expected %0d seen %0d", e, zone);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b1; regAddr = a; regWriteData = d;
    @(negedge clk);
    regWrite = 1'b0;
  endtask

  // Read data is taken a cycle and a half after the edge that takes the strobe, where it has settled.
  task automatic rdChk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    regRead = 1'b1; regAddr = a;
    @(negedge clk);
    regRead = 1'b0;
    @(negedge clk);
    chk(n, e, regReadData);
  endtask

  task automatic sample(input logic [7:0] code);
    @(negedge clk);
    sampleValid = 1'b1; sensorCode = code;
    @(negedge clk);
    sampleValid = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic t_reset();
    chk("outs", 8'h00, {4'h0, darkOut, indoorOut, officeOut, brightOut});
    chkZone(ambient_light_zone_pkg::ZONE_DAYLIGHT);
    rdChk("bright trip", 8'h32, 8'h00);
    rdChk("bright hyst", 8'h33, 8'h00);
    rdChk("office trip", 8'h34, 8'h00);
  endtask

  task automatic t_regs();
    wr(8'h32, 8'hf5);
    rdChk("bright trip", 8'h32, 8'hf5);
    wr(8'h33, 8'h05);
    rdChk("bright hyst", 8'h33, 8'h05);
    wr(8'h34, 8'hff);
    rdChk("office trip", 8'h34, 8'hff);
    wr(8'h31, 8'hff);
    rdChk("status", 8'h31, 8'h00);
    wr(8'h40, 8'h5a);
    rdChk("unmapped", 8'h40, 8'h00);
  endtask

  task automatic t_bright();
    levelEnable = 4'h1;
    wr(8'h32, 8'h40);
    wr(8'h33, 8'h10);
    wr(8'h34, 8'h00);
    sample(8'h3f);
    chkZone(ambient_light_zone_pkg::ZONE_BRIGHT);
    rdChk("status", 8'h31, 8'h01);
    sample(8'h50);
    chkZone(ambient_light_zone_pkg::ZONE_BRIGHT);
    sample(8'h51);
    chkZone(ambient_light_zone_pkg::ZONE_DAYLIGHT);
    rdChk("status", 8'h31, 8'h00);
    sample(8'h40);
    chkZone(ambient_light_zone_pkg::ZONE_DAYLIGHT);
  endtask

  task automatic t_office();
    levelEnable = 4'h3;
    officeZoneHysteresis = 8'h08;
    wr(8'h34, 8'h30);
    sample(8'h2f);
    chkZone(ambient_light_zone_pkg::ZONE_OFFICE);
    rdChk("status", 8'h31, 8'h03);
    sample(8'h39);
    chkZone(ambient_light_zone_pkg::ZONE_BRIGHT);
  endtask

  task automatic t_enables();
    indoorCompareIn = 1'b1;
    darkCompareIn = 1'b1;
    levelEnable = 4'hf;
    rdChk("status", 8'h31, 8'h0d);
    chk("outs", 8'h0d, {4'h0, darkOut, indoorOut, officeOut, brightOut});
    levelEnable = 4'h0;
    sample(8'h39);
    rdChk("status", 8'h31, 8'h00);
    chkZone(ambient_light_zone_pkg::ZONE_BRIGHT);
    levelEnable = 4'h1;
    wr(8'h33, 8'h00);
    wr(8'h32, 8'hfa);
    sample(8'hf9);
    rdChk("status", 8'h31, 8'h01);
  endtask

  initial begin
    bad_count = 0; comparisons = 0; cycles = 0;
    rst = 1'b1; regWrite = 1'b0; regRead = 1'b0; sampleValid = 1'b0;
    regAddr = 8'h00; regWriteData = 8'h00; sensorCode = 8'hff; levelEnable = 4'h0;
    officeZoneHysteresis = 8'h00; indoorCompareIn = 1'b0; darkCompareIn = 1'b0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_bright();
    t_office();
    t_enables();
    // A second reset in mid-run must bring registers and zone back to their start.
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    indoorCompareIn = 1'b0;
    darkCompareIn = 1'b0;
    t_reset();
    wrap_up();
  end
endmodule // ambient_light_zone_comparator_bench
